// ---- logic/mtc_pkg.sv ----
// shared constants and types for the transmit control and status block
package mtc_pkg;
  localparam int AddrW = 8;
  localparam int DataW = 16;
  localparam logic [7:0] TxCtrlOff = 8'h70;
  localparam logic [7:0] TxStatOff = 8'h72;
  localparam logic [7:0] IrqStatOff = 8'h7c;
  localparam logic [7:0] IrqMaskOff = 8'h7e;
  localparam int IcmpBit = 8;
  localparam int TcpBit = 6;
  localparam int IpBit = 5;
  localparam int FlushBit = 4;
  localparam int FlowBit = 3;
  localparam int PadBit = 2;
  localparam int CrcBit = 1;
  localparam int RunBit = 0;
  localparam int LateBit = 13;
  localparam int MaxBit = 12;
  localparam int FidW = 6;
  localparam logic [15:0] TxCtrlMask = 16'h017f;
  localparam logic [15:0] TxCtrlReset = 16'h0000;
  localparam logic [15:0] TxStatReset = 16'h0000;
  localparam int MinFrameBytes = 64;
  localparam int CrcBytes = 4;
  localparam int IrqW = 3;
  localparam int IrqDone = 0;
  localparam int IrqLate = 1;
  localparam int IrqMax = 2;
  localparam logic [2:0] IrqReset = 3'h0;

  typedef struct packed {
    logic icmpCsum;
    logic tcpCsum;
    logic ipCsum;
    logic padEn;
    logic crcEn;
    logic flowEn;
  } mtc_frame_opts_t;

  typedef struct packed {
    logic done;
    logic lateCol;
    logic maxCol;
    logic [5:0] fid;
  } mtc_tx_result_t;
endpackage : mtc_pkg

// ---- logic/mtc_status_capture.sv ----
// latches the status of the last finished frame as one unit
`timescale 1ns/1ns
module mtc_status_capture import mtc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire mtc_tx_result_t result,
  output logic [15:0] statusWord
);
  logic [15:0] status_q;
  logic [15:0] status_d;

  always_comb begin
    status_d = status_q;
    if (result.done) begin
      status_d = 16'h0000;
      status_d[LateBit] = result.lateCol;
      status_d[MaxBit] = result.maxCol;
      status_d[FidW-1:0] = result.fid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= TxStatReset;
    end else begin
      status_q <= status_d;
    end
  end

  assign statusWord = status_q;
endmodule : mtc_status_capture

// ---- logic/mac_transmit_control_status.sv ----
// transmit control register, run/stop sequencing, flow control and status
`timescale 1ns/1ns
module mac_transmit_control_status import mtc_pkg::*; #(
  parameter int PtrW = 11
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AddrW-1:0] regAddr,
  input wire logic [DataW-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DataW-1:0] regRdData,
  output logic irq,
  // engine side, same clock
  input wire logic frameReady,
  input wire logic [15:0] frameLen,
  input wire logic frameIsIp,
  input wire logic frameIsTcp,
  input wire logic frameIsIcmp,
  input wire logic frameFragmented,
  input wire logic [FidW-1:0] frameId,
  input wire logic frameEnd,
  input wire logic endLateCol,
  input wire logic endMaxCol,
  input wire logic rxAboveThreshold,
  // asynchronous pin level from the phy
  input wire logic fullDuplexPin,
  output logic frameStart,
  output logic transmitting,
  output logic [15:0] padBytes,
  output logic appendCrc,
  output logic insertIpCsum,
  output logic insertTcpCsum,
  output logic insertIcmpCsum,
  output logic sendPause,
  output logic backPressure,
  output logic queueClear,
  output logic [PtrW-1:0] framePtr
);
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } mtc_state_t;

  function automatic logic [15:0] padFor(input logic [15:0] len, input logic en);
    logic [15:0] body;
    body = 16'(MinFrameBytes - CrcBytes);
    padFor = (en && len < body) ? 16'(body - len) : 16'h0000;
  endfunction : padFor

  mtc_state_t state_q, state_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [IrqW-1:0] irqStat_q, irqStat_d;
  logic [IrqW-1:0] irqMask_q, irqMask_d;
  logic [DataW-1:0] rd_q, rd_d;
  logic irq_q, irq_d;
  mtc_frame_opts_t opts_q, opts_d;
  logic [15:0] pad_q, pad_d;
  logic start_q, start_d;
  logic pause_q, pause_d;
  logic bp_q, bp_d;
  logic clear_q, clear_d;
  logic [PtrW-1:0] ptr_q, ptr_d;
  logic pauseArm_q, pauseArm_d;
  logic tx_q, tx_d;
  logic dupSync1_q, dupSync2_q;
  logic [15:0] statusWord;
  mtc_tx_result_t result;

  // two-stage sync of the duplex pin
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dupSync1_q <= 1'b0;
      dupSync2_q <= 1'b0;
    end else begin
      dupSync1_q <= fullDuplexPin;
      dupSync2_q <= dupSync1_q;
    end
  end

  assign result.done = (state_q == ST_SEND) && frameEnd;
  assign result.lateCol = endLateCol;
  assign result.maxCol = endMaxCol;
  assign result.fid = frameId;

  mtc_status_capture u_status (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .result(result),
    .statusWord(statusWord)
  );

  // register file
  always_comb begin
    logic [IrqW-1:0] events;
    events = '0;
    ctrl_d = ctrl_q;
    irqMask_d = irqMask_q;
    rd_d = '0;
    events[IrqDone] = result.done;
    events[IrqLate] = result.done & endLateCol;
    events[IrqMax] = result.done & endMaxCol;
    irqStat_d = irqStat_q;
    if (regWrite) begin
      case (regAddr)
        TxCtrlOff: begin
          ctrl_d = regWrData & TxCtrlMask;
        end
        IrqStatOff: begin
          irqStat_d = irqStat_q & ~regWrData[IrqW-1:0];
        end
        IrqMaskOff: begin
          irqMask_d = regWrData[IrqW-1:0];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    irqStat_d = irqStat_d | events;
    if (regRead) begin
      case (regAddr)
        TxCtrlOff: rd_d = ctrl_q;
        TxStatOff: rd_d = statusWord;
        IrqStatOff: rd_d = {{(DataW-IrqW){1'b0}}, irqStat_q};
        IrqMaskOff: rd_d = {{(DataW-IrqW){1'b0}}, irqMask_q};
        default: rd_d = '0;
      endcase
    end
    irq_d = |(irqStat_d & irqMask_d);
  end

  // transmit sequencing
  always_comb begin
    state_d = state_q;
    opts_d = opts_q;
    pad_d = pad_q;
    start_d = 1'b0;
    clear_d = ctrl_q[FlushBit];
    ptr_d = ptr_q;
    if (ctrl_q[FlushBit]) begin
      ptr_d = '0;
    end else if (start_q) begin
      ptr_d = ptr_q + PtrW'(1);
    end
    case (state_q)
      ST_STOPPED: begin
        if (ctrl_q[RunBit] && !ctrl_q[FlushBit]) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!ctrl_q[RunBit] || ctrl_q[FlushBit]) begin
          state_d = ST_STOPPED;
        end else if (frameReady && !pause_q && !pause_d) begin
          // no start beside a pause that is about to go out
          state_d = ST_SEND;
          start_d = 1'b1;
          opts_d.crcEn = ctrl_q[CrcBit];
          opts_d.padEn = ctrl_q[PadBit];
          opts_d.ipCsum = ctrl_q[IpBit] & frameIsIp;
          opts_d.tcpCsum = ctrl_q[TcpBit] & frameIsTcp;
          opts_d.icmpCsum = ctrl_q[IcmpBit] & frameIsIcmp & ~frameFragmented;
          opts_d.flowEn = ctrl_q[FlowBit];
          pad_d = padFor(frameLen, ctrl_q[PadBit]);
        end
      end
      ST_SEND: begin
        // run bit is only looked at on frameEnd here so a frame is never cut short
        if (frameEnd) begin
          state_d = ctrl_q[RunBit] ? ST_IDLE : ST_STOPPED;
        end
      end
      default: state_d = ST_STOPPED;
    endcase
    tx_d = (state_d == ST_SEND);
  end

  // flow control: one pause per threshold crossing in full duplex, back-pressure in half duplex
  always_comb begin
    pause_d = 1'b0;
    bp_d = 1'b0;
    pauseArm_d = pauseArm_q;
    if (!rxAboveThreshold) begin
      pauseArm_d = 1'b1;
    end
    if (ctrl_q[FlowBit]) begin
      if (dupSync2_q) begin
        if (rxAboveThreshold && pauseArm_q && state_q != ST_SEND) begin
          pause_d = 1'b1;
          pauseArm_d = 1'b0;
        end
      end else begin
        bp_d = rxAboveThreshold;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_STOPPED;
      ctrl_q <= TxCtrlReset;
      irqStat_q <= IrqReset;
      irqMask_q <= IrqReset;
      rd_q <= '0;
      irq_q <= 1'b0;
      opts_q <= '0;
      pad_q <= '0;
      start_q <= 1'b0;
      pause_q <= 1'b0;
      bp_q <= 1'b0;
      clear_q <= 1'b0;
      ptr_q <= '0;
      pauseArm_q <= 1'b1;
      tx_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      rd_q <= rd_d;
      irq_q <= irq_d;
      opts_q <= opts_d;
      pad_q <= pad_d;
      start_q <= start_d;
      pause_q <= pause_d;
      bp_q <= bp_d;
      clear_q <= clear_d;
      ptr_q <= ptr_d;
      pauseArm_q <= pauseArm_d;
      tx_q <= tx_d;
    end
  end

  assign regRdData = rd_q;
  assign irq = irq_q;
  assign frameStart = start_q;
  assign transmitting = tx_q;
  assign padBytes = pad_q;
  assign appendCrc = opts_q.crcEn;
  assign insertIpCsum = opts_q.ipCsum;
  assign insertTcpCsum = opts_q.tcpCsum;
  assign insertIcmpCsum = opts_q.icmpCsum;
  assign sendPause = pause_q;
  assign backPressure = bp_q;
  assign queueClear = clear_q;
  assign framePtr = ptr_q;
endmodule : mac_transmit_control_status

// ---- tb/mtc_checker.sv ----
// port assertions for the transmit control and status block
`timescale 1ns/1ns
module mtc_checker import mtc_pkg::*; #(
  parameter int PtrW = 11
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regRead,
  input wire logic [DataW-1:0] regRdData,
  input wire logic [15:0] frameLen,
  input wire logic frameEnd,
  input wire logic rxAboveThreshold,
  input wire logic frameStart,
  input wire logic transmitting,
  input wire logic [15:0] padBytes,
  input wire logic sendPause,
  input wire logic backPressure,
  input wire logic queueClear,
  input wire logic [PtrW-1:0] framePtr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence frameDone;
    transmitting && frameEnd;
  endsequence
  sequence flushHeld;
    queueClear ##1 queueClear;
  endsequence
  a_start_opens_tx: assert property (frameStart |-> transmitting)
    else $error("start without transmitting");
  a_tx_holds_frame: assert property (transmitting && !frameEnd |=> transmitting)
    else $error("frame cut short");
  a_end_stops_tx: assert property (frameDone |=> !transmitting && !frameStart)
    else $error("no stop after frame end");
  a_rd_idle_zero: assert property (!$past(regRead) |-> regRdData == '0)
    else $error("read data outside read cycle");
  a_pad_count: assert property (frameStart |->
      padBytes == 16'h0000 || padBytes == 16'h003c - $past(frameLen))
    else $error("bad pad count");
  a_ptr_step: assert property (frameStart |=>
      framePtr == PtrW'($past(framePtr) + 1'h1))
    else $error("pointer not advanced");
  a_flush_ptr: assert property (flushHeld |-> framePtr == '0)
    else $error("pointer not cleared by flush");
  a_pause_pulse: assert property (sendPause |-> !transmitting ##1 !sendPause)
    else $error("pause not a lone pulse");
  a_pause_cause: assert property (sendPause |-> $past(rxAboveThreshold))
    else $error("pause without threshold");
  a_bp_cause: assert property (backPressure |-> $past(rxAboveThreshold) && !sendPause)
    else $error("back-pressure without threshold");
endmodule : mtc_checker

bind mac_transmit_control_status mtc_checker #(.PtrW(PtrW)) chkI (.sys_clk(sys_clk),
  .rst_n(rst_n), .regRead(regRead), .regRdData(regRdData), .frameLen(frameLen),
  .frameEnd(frameEnd), .rxAboveThreshold(rxAboveThreshold), .frameStart(frameStart),
  .transmitting(transmitting), .padBytes(padBytes), .sendPause(sendPause),
  .backPressure(backPressure), .queueClear(queueClear), .framePtr(framePtr));

// ---- tb/mtc_engine_model.sv ----
// far-side engine model: ends each frame after a set number of cycles
`timescale 1ns/1ns
module mtc_engine_model import mtc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic transmitting,
  input wire logic [3:0] holdCycles,
  input wire mtc_tx_result_t plan,
  output logic frameEnd,
  output logic endLateCol,
  output logic endMaxCol,
  output logic [FidW-1:0] frameId
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  always_comb begin
    cnt_d = (transmitting && !frameEnd) ? cnt_q + 4'h1 : 4'h0;
  end
  always_ff @(posedge sys_clk) begin
    cnt_q <= rst_n ? cnt_d : 4'h0;
  end
  assign frameEnd = transmitting && cnt_q == holdCycles;
  // results are junk outside the end pulse so a late sample shows up
  assign endLateCol = frameEnd ? plan.lateCol : ~plan.lateCol;
  assign endMaxCol = frameEnd ? plan.maxCol : ~plan.maxCol;
  assign frameId = frameEnd ? plan.fid : ~plan.fid;
endmodule : mtc_engine_model

// ---- tb/testbench.sv ----
// self-checking bench for the transmit control and status block
`timescale 1ns/1ns
module testbench import mtc_pkg::*; ;
  logic sys_clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, frameReady = 1'h0;
  logic isIp = 1'h0, isTcp = 1'h0, isIcmp = 1'h0, isFrag = 1'h0, rxAbove = 1'h0;
  logic fullDup = 1'h1, irq, fStart, txing, crc, cIp, cTcp, cIcmp, pause, bp, qClr;
  logic fEnd, late, maxC;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000, frameLen = 16'h0000, ctrl = 16'h0000;
  logic [15:0] regRdData, padBytes;
  logic [5:0] fid;
  logic [10:0] ptr;
  logic [3:0] hold = 4'h3;
  mtc_tx_result_t plan = '0;
  int err_total = 0, num_checks = 0;
  always #25 sys_clk = ~sys_clk;
  mac_transmit_control_status #(.PtrW(11)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .irq(irq), .frameReady(frameReady), .frameLen(frameLen),
    .frameIsIp(isIp), .frameIsTcp(isTcp), .frameIsIcmp(isIcmp), .frameFragmented(isFrag),
    .frameId(fid), .frameEnd(fEnd), .endLateCol(late), .endMaxCol(maxC),
    .rxAboveThreshold(rxAbove), .fullDuplexPin(fullDup), .frameStart(fStart),
    .transmitting(txing), .padBytes(padBytes), .appendCrc(crc), .insertIpCsum(cIp),
    .insertTcpCsum(cTcp), .insertIcmpCsum(cIcmp), .sendPause(pause), .backPressure(bp),
    .queueClear(qClr), .framePtr(ptr));
  mtc_engine_model eng (.sys_clk(sys_clk), .rst_n(rst_n), .transmitting(txing),
    .holdCycles(hold), .plan(plan), .frameEnd(fEnd), .endLateCol(late),
    .endMaxCol(maxC), .frameId(fid));
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
    @(posedge sys_clk);
  endtask : wr
  task automatic setc(input logic [15:0] d);
    ctrl = d;
    wr(TxCtrlOff, d);
  endtask : setc
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    @(negedge sys_clk);
    chk(n, regRdData, e);
    @(posedge sys_clk);
  endtask : rd
  // bounded wait: 0 start, 1 idle, 2 pause
  task automatic wt(input int k);
    for (int j = 0; j < 40; j++) begin
      @(negedge sys_clk);
      if (k == 0 && fStart === 1'h1 || k == 1 && txing === 1'h0) return;
      if (k == 2 && pause === 1'h1) return;
    end
    err_total++;
    complete_run();
  endtask : wt
  task automatic frame(input logic [15:0] n, input logic [3:0] c, input mtc_tx_result_t r);
    {isIp, isTcp, isIcmp, isFrag} <= c;
    frameLen <= n;
    plan <= r;
    frameReady <= 1'h1;
    wt(0);
    chk("crc", crc, ctrl[CrcBit]);
    chk("ipcs", cIp, ctrl[IpBit] & c[3]);
    chk("tcpcs", cTcp, ctrl[TcpBit] & c[2]);
    chk("icmpcs", cIcmp, ctrl[IcmpBit] & c[1] & !c[0]);
    chk("pad", padBytes, ctrl[PadBit] && n < 60 ? 16'h003c - n : 16'h0000);
    @(posedge sys_clk);
    frameReady <= 1'h0;
    wt(1);
    @(posedge sys_clk);
    rd(TxStatOff, {2'h0, r.lateCol, r.maxCol, 6'h00, r.fid}, "stat");
  endtask : frame
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    rd(TxCtrlOff, TxCtrlReset, "ctrl");
    rd(TxStatOff, TxStatReset, "stat");
    setc(16'hffff);
    rd(TxCtrlOff, 16'h017f, "ctrl");
    wr(TxStatOff, 16'hffff);
    rd(TxStatOff, 16'h0000, "stat");
    rd(8'h40, 16'h0000, "unmapped");
    setc(16'h0000);
    wr(IrqMaskOff, 16'h0007);
    setc(16'h0167);
    frame(16'h002a, 4'ha, 9'h085);
    frame(16'h003c, 4'hc, 9'h06a);
    frame(16'h003b, 4'h3, 9'h0ff);
    setc(16'h0001);
    frame(16'h0010, 4'he, 9'h011);
    chk("irq", irq, 1'h1);
    rd(IrqStatOff, 16'h0007, "irqstat");
    wr(IrqStatOff, 16'h0007);
    rd(IrqStatOff, 16'h0000, "irqstat");
    chk("irq", irq, 1'h0);
    wr(IrqMaskOff, 16'h0000);
    frame(16'h0040, 4'h0, 9'h000);
    chk("irq", irq, 1'h0);
    rd(IrqStatOff, 16'h0001, "irqstat");
    // stop request in mid-frame; ready stays up to show the stop sticks
    hold <= 4'h8;
    frameReady <= 1'h1;
    wt(0);
    @(posedge sys_clk);
    setc(16'h0000);
    @(negedge sys_clk);
    chk("txing", txing, 1'h1);
    wt(1);
    repeat (4) @(negedge sys_clk);
    chk("txing", txing, 1'h0);
    @(posedge sys_clk);
    frameReady <= 1'h0;
    setc(16'h0010);
    repeat (3) @(negedge sys_clk);
    chk("qclr", qClr, 1'h1);
    chk("ptr", ptr, 16'h0000);
    @(posedge sys_clk);
    setc(16'h0000);
    repeat (3) @(negedge sys_clk);
    chk("qclr", qClr, 1'h0);
    @(posedge sys_clk);
    setc(16'h0008);
    rxAbove <= 1'h1;
    wt(2);
    @(posedge sys_clk);
    rxAbove <= 1'h0;
    fullDup <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rxAbove <= 1'h1;
    repeat (3) @(negedge sys_clk);
    chk("bp", bp, 1'h1);
    chk("pause", pause, 1'h0);
    @(posedge sys_clk);
    setc(16'h0000);
    repeat (3) @(negedge sys_clk);
    chk("bp", bp, 1'h0);
    complete_run();
  end
endmodule : testbench
